/* File: design/zfg_params.svh */
`ifndef ZFG_PARAMS_SVH
`define ZFG_PARAMS_SVH

`define ZFG_IDX_POLARITY   7'h0a
`define ZFG_IDX_OSR_GPO    7'h0c
`define ZFG_BIT_RW         15
`define ZFG_IDX_HI         14
`define ZFG_IDX_LO         8
`define ZFG_BIT_OVER       7
`define ZFG_BIT_GP_OUT_ENABLE       6
`define ZFG_BIT_POLARITY   6
`define ZFG_GPO_RESET      6'h00
`define ZFG_ZERO_RUN       1024
`define ZFG_CHANNELS       8
`define ZFG_GP_PINS        6
`define ZFG_SAMPLE_BITS    24

`endif

/* File: design/zfg_pkg.sv */
`default_nettype none
package zfg_pkg;
  typedef enum logic [1:0] {ZFG_OSR_32, ZFG_OSR_64, ZFG_OSR_128} zfg_osr_t;
  typedef logic [15:0] zfg_word_t;
  typedef logic [7:0]  zfg_byte_t;
endpackage : zfg_pkg
`default_nettype wire

/* File: design/zfg_zero_detect.sv */
`timescale 1ns/10ps
`default_nettype none
`include "zfg_params.svh"
module zfg_zero_detect #(
  parameter int RUN = `ZFG_ZERO_RUN,
  parameter int CW  = $clog2(RUN + 1)
) (
  input  wire logic clk,
  input  wire logic rstn,
  input  wire logic frame_tick,
  input  wire logic sample_zero,
  output logic      silent
);
  logic [CW-1:0] run_count;

  // saturating run of zero frames
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      run_count <= '0;
    end else if (frame_tick) begin
      if (!sample_zero) begin
        run_count <= '0;
      end else if (run_count != CW'(RUN)) begin
        run_count <= run_count + 1'b1;
      end
    end
  end

  assign silent = (run_count == CW'(RUN));

  ////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);

  run_reach_a: assert property (
    frame_tick && sample_zero && run_count == CW'(RUN - 1) |=> silent)
    else $error("flag not set after full zero run");
  nonzero_clear_a: assert property (
    frame_tick && !sample_zero |=> !silent && run_count == '0)
    else $error("nonzero sample did not clear the run");
  hold_no_tick_a: assert property (
    !frame_tick |=> $stable(run_count))
    else $error("run count moved without a frame");
endmodule : zfg_zero_detect
`default_nettype wire

/* File: design/zfg_flag_gpo.sv */
`timescale 1ns/10ps
`default_nettype none
`include "zfg_params.svh"
module zfg_flag_gpo
  import zfg_pkg::*;
#(
  parameter int CH   = `ZFG_CHANNELS,
  parameter int GP   = `ZFG_GP_PINS,
  parameter int SW   = `ZFG_SAMPLE_BITS,
  parameter int RUN  = `ZFG_ZERO_RUN
) (
  input  wire logic              clk,
  input  wire logic              rstn,
  input  wire logic              frame_clock,
  input  wire logic [CH*SW-1:0]  chan_sample,
  input  wire logic              low_ratio_clock,
  input  wire logic              ctrl_valid,
  input  wire zfg_pkg::zfg_word_t ctrl_word,
  output zfg_pkg::zfg_byte_t     rd_data,
  output logic                   rd_valid,
  output zfg_pkg::zfg_osr_t      osr_select,
  output logic [GP-1:0]          shared_pin,
  output logic [CH-1:GP]         chan_silence_flag,
  output logic                   all_silent_flag
);
  import zfg_pkg::*;

  logic          frame_prev;
  logic          frame_tick;
  logic [CH-1:0] silent;
  logic          over_sel;
  logic          gp_out_enable;
  logic [GP-1:0] gp_out_level;
  logic          flag_polarity_invert;
  zfg_osr_t      next_osr;

  function automatic logic hit(input zfg_word_t w, input logic [6:0] idx);
    hit = (w[`ZFG_IDX_HI:`ZFG_IDX_LO] == idx);
  endfunction : hit

  function automatic logic is_write(input zfg_word_t w);
    is_write = !w[`ZFG_BIT_RW];
  endfunction : is_write

  ////////////////////////////////////////////////////////////////////////////
  // frame clock rising edge as one-cycle enable
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      frame_prev <= 1'b0;
    end else begin
      frame_prev <= frame_clock;
    end
  end
  assign frame_tick = frame_clock && !frame_prev;

  genvar c;
  generate
    for (c = 0; c < CH; c++) begin : g_chan
      zfg_zero_detect #(.RUN(RUN)) u_det (
        .clk         (clk),
        .rstn        (rstn),
        .frame_tick  (frame_tick),
        .sample_zero (chan_sample[c*SW +: SW] == '0),
        .silent      (silent[c])
      );
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // register writes
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      over_sel      <= 1'b0;
      gp_out_enable <= 1'b0;
      gp_out_level  <= `ZFG_GPO_RESET;
    end else if (ctrl_valid && is_write(ctrl_word) && hit(ctrl_word, `ZFG_IDX_OSR_GPO)) begin
      over_sel      <= ctrl_word[`ZFG_BIT_OVER];
      gp_out_enable <= ctrl_word[`ZFG_BIT_GP_OUT_ENABLE];
      gp_out_level  <= ctrl_word[GP-1:0];
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      flag_polarity_invert <= 1'b0;
    end else if (ctrl_valid && is_write(ctrl_word) && hit(ctrl_word, `ZFG_IDX_POLARITY)) begin
      flag_polarity_invert <= ctrl_word[`ZFG_BIT_POLARITY];
    end
  end

  // register reads
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      rd_data  <= '0;
      rd_valid <= 1'b0;
    end else begin
      rd_valid <= ctrl_valid && !is_write(ctrl_word);
      if (ctrl_valid && !is_write(ctrl_word)) begin
        if (hit(ctrl_word, `ZFG_IDX_OSR_GPO)) begin
          rd_data <= {over_sel, gp_out_enable, gp_out_level};
        end else if (hit(ctrl_word, `ZFG_IDX_POLARITY)) begin
          rd_data <= zfg_byte_t'(flag_polarity_invert) << `ZFG_BIT_POLARITY;
        end else begin
          rd_data <= '0;
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // oversampling select
  always_comb begin
    case ({low_ratio_clock, over_sel})
      2'b00:   next_osr = ZFG_OSR_64;
      2'b01:   next_osr = ZFG_OSR_128;
      2'b10:   next_osr = ZFG_OSR_32;
      2'b11:   next_osr = ZFG_OSR_64;
      default: next_osr = ZFG_OSR_64;
    endcase
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      osr_select <= ZFG_OSR_64;
    end else begin
      osr_select <= next_osr;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // shared pins: zero flags or level bits
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      shared_pin <= '0;
    end else if (gp_out_enable) begin
      shared_pin <= gp_out_level;
    end else begin
      shared_pin <= silent[GP-1:0] ^ {GP{flag_polarity_invert}};
    end
  end

  // upper channel flags never taken over by the level bits
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      chan_silence_flag <= '0;
    end else begin
      chan_silence_flag <= silent[CH-1:GP] ^ {(CH-GP){flag_polarity_invert}};
    end
  end

  // all-channel flag
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      all_silent_flag <= 1'b0;
    end else begin
      all_silent_flag <= (&silent) ^ flag_polarity_invert;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);

  gpo_write_a: assert property (
    ctrl_valid && !ctrl_word[`ZFG_BIT_RW] && hit(ctrl_word, `ZFG_IDX_OSR_GPO)
    |=> gp_out_level == $past(ctrl_word[GP-1:0]))
    else $error("level bits not written");
  read_no_write_a: assert property (
    ctrl_valid && ctrl_word[`ZFG_BIT_RW] |=> rd_valid && $stable(gp_out_level)
      && $stable(over_sel) && $stable(gp_out_enable))
    else $error("read changed register or gave no answer");
  read_value_a: assert property (
    ctrl_valid && ctrl_word[`ZFG_BIT_RW] && hit(ctrl_word, `ZFG_IDX_OSR_GPO)
    |=> rd_data == {$past(over_sel), $past(gp_out_enable), $past(gp_out_level)})
    else $error("read data wrong");
  osr_map_a: assert property (
    !low_ratio_clock ##1 1 |-> osr_select == ($past(over_sel) ? ZFG_OSR_128 : ZFG_OSR_64))
    else $error("oversampling wrong at high ratio");
  osr_low_a: assert property (
    low_ratio_clock ##1 1 |-> osr_select == ($past(over_sel) ? ZFG_OSR_64 : ZFG_OSR_32))
    else $error("oversampling wrong at low ratio");
  pin_flag_a: assert property (
    !gp_out_enable |=> shared_pin == ($past(silent[GP-1:0]) ^ {GP{$past(flag_polarity_invert)}}))
    else $error("shared pins not showing flags");
  pin_gpo_a: assert property (
    gp_out_enable |=> shared_pin == $past(gp_out_level))
    else $error("shared pins not showing levels");
  all_and_a: assert property (
    1 |=> all_silent_flag == ((&$past(silent)) ^ $past(flag_polarity_invert)))
    else $error("all-silent flag wrong");
  high_flag_a: assert property (
    silent[CH-1] && flag_polarity_invert |=> !chan_silence_flag[CH-1])
    else $error("inverted flag not low at silence");
  tick_pulse_a: assert property (frame_tick |=> !frame_tick)
    else $error("frame tick longer than one cycle");

  ////////////////////////////////////////////////////////////////////////////
  // register file and flag checks
  pol_write_a: assert property (
    ctrl_valid && !ctrl_word[`ZFG_BIT_RW] && hit(ctrl_word, `ZFG_IDX_POLARITY)
    |=> flag_polarity_invert == $past(ctrl_word[`ZFG_BIT_POLARITY]))
    else $error("polarity bit not written");
  pol_read_a: assert property (
    ctrl_valid && ctrl_word[`ZFG_BIT_RW] && hit(ctrl_word, `ZFG_IDX_POLARITY)
    |=> rd_data[`ZFG_BIT_POLARITY] == $past(flag_polarity_invert))
    else $error("polarity bit read wrong");
  other_read_a: assert property (
    ctrl_valid && ctrl_word[`ZFG_BIT_RW] && !hit(ctrl_word, `ZFG_IDX_OSR_GPO)
      && !hit(ctrl_word, `ZFG_IDX_POLARITY) |=> rd_data == '0)
    else $error("unused index read not zero");
  read_hold_a: assert property (
    !(ctrl_valid && ctrl_word[`ZFG_BIT_RW]) |=> !rd_valid && $stable(rd_data))
    else $error("read answer without a read");
  reg_keep_a: assert property (
    !(ctrl_valid && !ctrl_word[`ZFG_BIT_RW] && hit(ctrl_word, `ZFG_IDX_OSR_GPO))
    |=> $stable(gp_out_level) && $stable(gp_out_enable) && $stable(over_sel))
    else $error("control bits moved without a write");
  flag_high_a: assert property (
    silent[0] && !flag_polarity_invert && !gp_out_enable |=> shared_pin[0])
    else $error("silent channel flag not high");
  pol_flag_a: assert property (
    silent[0] && flag_polarity_invert && !gp_out_enable |=> !shared_pin[0])
    else $error("inverted pin flag not low at silence");
  upper_flag_a: assert property (
    1 |=> chan_silence_flag
      == ($past(silent[CH-1:GP]) ^ {(CH-GP){$past(flag_polarity_invert)}}))
    else $error("upper channel flags wrong");
endmodule : zfg_flag_gpo
`default_nettype wire

/* File: bench/zfg_frame_src.sv */
`timescale 1ns/10ps
`default_nettype none
module zfg_frame_src (
  input  wire logic clk,
  input  wire logic rstn,
  output logic      frame_clock
);
  logic [2:0] cnt;
  // one frame every eight system clocks, four high and four low
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      cnt <= 3'h0;
    end else begin
      cnt <= cnt + 3'h1;
    end
  end
  assign frame_clock = cnt[2];
endmodule : zfg_frame_src
`default_nettype wire

/* File: bench/tb.sv */
`timescale 1ns/10ps
`default_nettype none
module tb;
  import zfg_pkg::*;
  localparam int RUN = 4;
  logic         clk, rstn, low_ratio_clock, ctrl_valid, frame_clock;
  logic         rd_valid, all_silent_flag;
  logic [191:0] chan_sample;
  zfg_word_t    ctrl_word;
  zfg_byte_t    rd_data;
  zfg_osr_t     osr_select;
  logic [5:0]   shared_pin;
  logic [7:6]   chan_silence_flag;
  int           n_errors, cmp_count, cycles;
  zfg_frame_src FSRC (.clk(clk), .rstn(rstn), .frame_clock(frame_clock));
  zfg_flag_gpo #(.RUN(RUN)) DUT (.clk(clk), .rstn(rstn), .frame_clock(frame_clock),
    .chan_sample(chan_sample), .low_ratio_clock(low_ratio_clock), .ctrl_valid(ctrl_valid),
    .ctrl_word(ctrl_word), .rd_data(rd_data), .rd_valid(rd_valid), .osr_select(osr_select),
    .shared_pin(shared_pin), .chan_silence_flag(chan_silence_flag),
    .all_silent_flag(all_silent_flag));
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  task automatic end_sim();
    if (n_errors == 0 && cmp_count > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : end_sim
  always @(posedge clk) begin
    cycles++;
    if (cycles == 5000) begin
      n_errors++;
      end_sim();
    end
  end
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    cmp_count++;
    if (got !== exp) begin
      n_errors++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  // one control word; v is the one-cycle read strobe, taken while it stands
  task automatic ctl(input logic [15:0] w, output logic v);
    @(posedge clk);
    ctrl_valid <= 1'b1;
    ctrl_word  <= w;
    @(posedge clk);
    ctrl_valid <= 1'b0;
    #1;
    v = rd_valid;
    @(posedge clk);
    #1;
  endtask : ctl
  task automatic wr(input logic [6:0] idx, input logic [7:0] d);
    logic v;
    ctl({1'b0, idx, d}, v);
    chk({15'h0000, v}, 16'h0000);
  endtask : wr
  task automatic rd(input logic [6:0] idx, input logic [7:0] exp);
    logic v;
    ctl({1'b1, idx, 8'h00}, v);
    chk({15'h0000, v}, 16'h0001);
    chk({15'h0000, rd_valid}, 16'h0000);
    chk({8'h00, rd_data}, {8'h00, exp});
  endtask : rd
  task automatic pins(input logic [5:0] s, input logic [1:0] f, input logic a);
    chk({7'h00, a, chan_silence_flag, shared_pin}, {7'h00, a, f, s});
  endtask : pins
  task automatic frames(input int n);
    repeat (n * 8) @(posedge clk);
    #1;
  endtask : frames
  task automatic settle();
    repeat (3) @(posedge clk);
    #1;
  endtask : settle
  // bit c set makes channel c carry zero data
  task automatic zero(input logic [7:0] m);
    @(posedge clk);
    for (int c = 0; c < 8; c++) chan_sample[c*24+:24] <= m[c] ? 24'h00_0000 : 24'h00_0100;
  endtask : zero
  task automatic t_reset();
    pins(6'h00, 2'b00, 1'b0);
    chk({14'h0000, osr_select}, {14'h0000, ZFG_OSR_64});
    rd(7'h0c, 8'h00);
    rd(7'h05, 8'h00);
  endtask : t_reset
  task automatic t_gpo();
    for (int i = 0; i < 6; i++) begin
      wr(7'h0c, 8'h40 | (8'h01 << i));
      chk({10'h000, shared_pin}, 16'h0001 << i);
      rd(7'h0c, 8'h40 | (8'h01 << i));
    end
    wr(7'h0c, 8'h3f);
    pins(6'h00, 2'b00, 1'b0);
    wr(7'h0c, 8'h00);
  endtask : t_gpo
  task automatic t_osr();
    zfg_osr_t e;
    for (int l = 0; l < 2; l++) begin
      for (int o = 0; o < 2; o++) begin
        @(posedge clk);
        low_ratio_clock <= l[0];
        wr(7'h0c, {o[0], 7'h00});
        e = l ? (o ? ZFG_OSR_64 : ZFG_OSR_32) : (o ? ZFG_OSR_128 : ZFG_OSR_64);
        chk({14'h0000, osr_select}, {14'h0000, e});
      end
    end
    @(posedge clk);
    low_ratio_clock <= 1'b0;
    wr(7'h0c, 8'h00);
  endtask : t_osr
  task automatic t_zero();
    zero(8'h81);
    frames(RUN - 1);
    pins(6'h00, 2'b00, 1'b0);
    frames(1);
    settle();
    pins(6'h01, 2'b10, 1'b0);
    wr(7'h0c, 8'h55);
    pins(6'h15, 2'b10, 1'b0);
    wr(7'h0c, 8'h00);
    zero(8'hff);
    frames(RUN);
    settle();
    pins(6'h3f, 2'b11, 1'b1);
    wr(7'h0a, 8'h40);
    pins(6'h00, 2'b00, 1'b0);
    rd(7'h0a, 8'h40);
    wr(7'h0a, 8'h00);
    zero(8'hf7);
    frames(1);
    settle();
    pins(6'h37, 2'b11, 1'b0);
  endtask : t_zero
  initial begin
    rstn            = 1'b0;
    ctrl_valid      = 1'b0;
    ctrl_word       = 16'h0000;
    low_ratio_clock = 1'b0;
    chan_sample     = {8{24'h00_0100}};
    n_errors        = 0;
    cmp_count       = 0;
    cycles          = 0;
    repeat (4) @(posedge clk);
    rstn <= 1'b1;
    @(posedge clk);
    #1;
    t_reset();
    t_gpo();
    t_osr();
    t_zero();
    end_sim();
  end
endmodule : tb
`default_nettype wire
